// >>> verilog/supply_mode_control_regs.sv
// supply_mode_control_regs: supply source and booster control nibbles
// assumes: single ahb-lite master, word transfers, analog circuits outside
`timescale 1ns/1ps
module supply_mode_control_regs (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // supply and mode controls to the analog side
  output logic booster_enable_o,
  output logic osc_regulator_supply_select_o,
  output logic converter_supply_select_o,
  output logic [1:0] lcd_duty_select_o,
  output logic spare_general_bit_o
);

  // ----------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------
  logic addr_valid;
  logic wr_pending;
  logic [31:0] wr_addr;
  logic take_phase;

  // a transfer is taken when selected, active and the bus is ready
  assign take_phase = hsel_i && hready_i && (htrans_i == supply_mode_pkg::HTRANS_NONSEQ ||
    htrans_i == supply_mode_pkg::HTRANS_SEQ);

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      addr_valid <= 1'b0;
      wr_pending <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end
    else if (hready_i)
    begin
      addr_valid <= take_phase;
      wr_pending <= take_phase && hwrite_i;
      wr_addr <= haddr_i;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic write_select;
  logic write_booster;
  logic [3:0] select_value;
  logic [3:0] booster_value;

  assign write_select = wr_pending && (wr_addr == supply_mode_pkg::SUPPLY_SOURCE_SELECT_ADDR);
  assign write_booster = wr_pending && (wr_addr == supply_mode_pkg::BOOSTER_LCD_CONTROL_ADDR);

  nibble_store #(
    .IMPL_MASK(supply_mode_pkg::SUPPLY_SOURCE_SELECT_MASK),
    .RESET_VALUE(supply_mode_pkg::SUPPLY_SOURCE_SELECT_RESET)
  ) u_select (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .write_i(write_select),
    .wdata_i(hwdata_i[3:0]),
    .value_o(select_value)
  );

  nibble_store #(
    .IMPL_MASK(supply_mode_pkg::BOOSTER_LCD_CONTROL_MASK),
    .RESET_VALUE(supply_mode_pkg::BOOSTER_LCD_CONTROL_RESET)
  ) u_booster (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .write_i(write_booster),
    .wdata_i(hwdata_i[3:0]),
    .value_o(booster_value)
  );

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // sequencing toward the boosted rail is left to software: no interlock,
  // so a premature select is passed straight through to the analog side
  // booster drive
  assign booster_enable_o = booster_value[supply_mode_pkg::BOOSTER_ENABLE_BIT];
  assign osc_regulator_supply_select_o = select_value[supply_mode_pkg::OSC_REGULATOR_SUPPLY_SELECT_BIT];
  assign converter_supply_select_o = select_value[supply_mode_pkg::CONVERTER_SUPPLY_SELECT_BIT];
  assign lcd_duty_select_o = {booster_value[supply_mode_pkg::LCD_DUTY_SELECT_HI_BIT],
    booster_value[supply_mode_pkg::LCD_DUTY_SELECT_LO_BIT]};
  assign spare_general_bit_o = booster_value[supply_mode_pkg::SPARE_GENERAL_BIT];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  // unmapped addresses read zero and still answer okay
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (take_phase && !hwrite_i)
    begin
      if (haddr_i == supply_mode_pkg::SUPPLY_SOURCE_SELECT_ADDR)
        next_rdata = {28'h000_0000, select_value & supply_mode_pkg::SUPPLY_SOURCE_SELECT_MASK};
      else if (haddr_i == supply_mode_pkg::BOOSTER_LCD_CONTROL_ADDR)
        next_rdata = {28'h000_0000, booster_value};
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hrdata_o <= 32'h0000_0000;
    else if (hready_i)
      hrdata_o <= next_rdata;
  end

  // zero wait states, never an error
  assign hreadyout_o = 1'b1;
  assign hresp_o = supply_mode_pkg::HRESP_OKAY;

endmodule : supply_mode_control_regs

// >>> verilog/supply_mode_pkg.sv
// supply_mode_pkg: offsets, field positions, reset values and bus codes
// assumes: used by the supply mode register block and its testbench; the nibble store only takes parameters
package supply_mode_pkg;

  // ----------------------------------------------------------------
  // register map (printed offsets are not all multiples of four: index)
  // ----------------------------------------------------------------
  localparam logic [15:0] SUPPLY_SOURCE_SELECT_IDX = 16'hff01;
  localparam logic [15:0] BOOSTER_LCD_CONTROL_IDX = 16'hff60;
  localparam logic [31:0] SUPPLY_SOURCE_SELECT_ADDR = {14'h0000, SUPPLY_SOURCE_SELECT_IDX, 2'b00};
  localparam logic [31:0] BOOSTER_LCD_CONTROL_ADDR = {14'h0000, BOOSTER_LCD_CONTROL_IDX, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONVERTER_SUPPLY_SELECT_BIT = 3;
  localparam int OSC_REGULATOR_SUPPLY_SELECT_BIT = 2;
  localparam int LCD_DUTY_SELECT_HI_BIT = 3;
  localparam int LCD_DUTY_SELECT_LO_BIT = 2;
  localparam int SPARE_GENERAL_BIT = 1;
  localparam int BOOSTER_ENABLE_BIT = 0;

  // implemented bits of each nibble; the rest read zero
  localparam logic [3:0] SUPPLY_SOURCE_SELECT_MASK = 4'hc;
  localparam logic [3:0] BOOSTER_LCD_CONTROL_MASK = 4'hf;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SUPPLY_SOURCE_SELECT_RESET = 4'h0;
  localparam logic [3:0] BOOSTER_LCD_CONTROL_RESET = 4'h0;

  // ----------------------------------------------------------------
  // ahb-lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : supply_mode_pkg

// >>> verilog/nibble_store.sv
// nibble_store: one 4-bit i/o location with per-bit implement mask
// assumes: write strobe and data come from the bus slave on the same clock
`timescale 1ns/1ps
module nibble_store #(
  parameter logic [3:0] IMPL_MASK = 4'hf,
  parameter logic [3:0] RESET_VALUE = 4'h0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // write side
  input wire logic write_i,
  input wire logic [3:0] wdata_i,
  // stored value, unimplemented bits zero
  output logic [3:0] value_o
);

  // ----------------------------------------------------------------
  // per-bit storage
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_bit
      if (IMPL_MASK[b])
      begin : g_impl
        always_ff @(posedge ref_clk_i or negedge reset_n_i)
        begin
          if (!reset_n_i)
            value_o[b] <= RESET_VALUE[b];
          else if (write_i)
            value_o[b] <= wdata_i[b];
        end
      end
      else
      begin : g_unused
        // no flop: the bit does not exist and reads zero
        assign value_o[b] = 1'b0;
      end
    end
  endgenerate

endmodule : nibble_store

// >>> bench/supply_mode_checker.sv
// supply_mode_checker: port assertions for the supply mode register block
// assumes: bound to the top module, zero-wait slave, data phase follows address
`timescale 1ns/1ps
module supply_mode_checker (
  input wire logic ref_clk_i, reset_n_i, hsel_i, hwrite_i, hready_i,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i, hrdata_o,
  input wire logic booster_enable_o, osc_regulator_supply_select_o,
  input wire logic converter_supply_select_o, spare_general_bit_o,
  input wire logic [1:0] lcd_duty_select_o
);
  logic wp;
  logic [31:0] wa;
  wire logic wb = wp && wa == 32'h0003_fd80;
  wire logic ws = wp && wa == 32'h0003_fc04;
  wire logic rs = hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 32'h0003_fc04;
  // remembers the address phase so the data phase can be judged
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      wp <= 1'b0;
      wa <= 32'h0000_0000;
    end
    else if (hready_i)
    begin
      wp <= hsel_i && htrans_i[1] && hwrite_i;
      wa <= haddr_i;
    end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_booster_write: assert property (wb |=> booster_enable_o == $past(hwdata_i[0]))
    else $error("booster enable not written");
  a_osc_select_write: assert property (ws |=> osc_regulator_supply_select_o == $past(hwdata_i[2]))
    else $error("oscillator select not written");
  a_conv_select_write: assert property (ws |=> converter_supply_select_o == $past(hwdata_i[3]))
    else $error("converter select not written");
  // a read overlapping a write data phase is excluded: either value is legal
  a_unused_bits_zero: assert property (rs && !wp |=> hrdata_o == {28'h000_0000, converter_supply_select_o,
    osc_regulator_supply_select_o, 2'b00}) else $error("select readback wrong");
  a_duty_field_write: assert property (wb |=> lcd_duty_select_o == $past(hwdata_i[3:2]))
    else $error("duty field not written");
  a_spare_bit_write: assert property (wb |=> spare_general_bit_o == $past(hwdata_i[1]))
    else $error("spare bit not written");
  a_outputs_hold: assert property (!wp |=> $stable({booster_enable_o, osc_regulator_supply_select_o,
    converter_supply_select_o, lcd_duty_select_o, spare_general_bit_o})) else $error("output moved");
  c_booster_on: cover property (wb ##1 booster_enable_o);
  c_select_read: cover property (rs);
  c_unmapped_write: cover property (wp && !wb && !ws);
  c_rail_mode: cover property (booster_enable_o && osc_regulator_supply_select_o && converter_supply_select_o);
endmodule : supply_mode_checker
bind supply_mode_control_regs supply_mode_checker u_checker (.*);

// >>> bench/supply_mode_control_regs_tb.sv
// supply_mode_control_regs_tb: ahb-lite master tests of both nibbles
// assumes: one slave, hready looped back, hsize fixed to word
`timescale 1ns/1ps
module supply_mode_control_regs_tb;
  logic ref_clk_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [1:0] htrans_i, lcd_duty_select_o;
  logic [2:0] hsize_i = supply_mode_pkg::HSIZE_WORD;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
  logic booster_enable_o, osc_regulator_supply_select_o, converter_supply_select_o, spare_general_bit_o;
  wire logic hready_i = hreadyout_o;
  wire logic [31:0] ob = {28'h000_0000, lcd_duty_select_o, spare_general_bit_o, booster_enable_o};
  wire logic [31:0] os = {28'h000_0000, converter_supply_select_o, osc_regulator_supply_select_o, 2'b00};
  localparam logic [31:0] BA = 32'h0003_fd80, SA = 32'h0003_fc04, UA = 32'h0000_0010;
  int n_errors = 0, comparisons = 0, cyc = 0;
  supply_mode_control_regs u_dut (.*);
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // address phase held until hready, then data phase; read data taken at its end
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= supply_mode_pkg::HTRANS_NONSEQ;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    r = hrdata_o;
  endtask : xfer
  task automatic stop_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    {reset_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    xfer(BA, 1'b0, 0); chk(r, 0);
    xfer(SA, 1'b0, 0); chk(r, 0);
    chk({30'h0000_0000, hreadyout_o, hresp_o}, 32'h0000_0002);
    // upper bits set on purpose: only the implemented bits may stick
    for (int i = 0; i < 16; i++)
    begin
      xfer(BA, 1'b1, 32'hffff_fff0 | i);
      xfer(BA, 1'b0, 0); chk(r, i);
      xfer(SA, 1'b1, 32'hffff_fff0 | i);
      xfer(SA, 1'b0, 0); chk(r, i & 4'hc);
      chk(os, i & 4'hc);
      chk(ob, i);
    end
    xfer(UA, 1'b1, 32'h0000_0000);
    xfer(UA, 1'b0, 0); chk(r, 0);
    chk(ob | os, 32'h0000_000f);
    // booster first, then the selects (settling wait omitted)
    // bench models a low supply: rail mode is legal
    // fast oscillator never enabled here, so rail mode may be entered
    xfer(BA, 1'b1, 1); xfer(SA, 1'b1, 32'h0000_000c);
    // selects cleared and booster stopped in separate writes
    xfer(SA, 1'b1, 0); xfer(BA, 1'b1, 0);
    xfer(BA, 1'b0, 0); chk(ob | os, 0);
    xfer(BA, 1'b1, 32'h0000_0006);
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    xfer(BA, 1'b0, 0); chk(r, 0);
    stop_test();
  end
endmodule : supply_mode_control_regs_tb
